// ### design/icb_pin_logic.sv
// Pin-function logic for user interrupts, clock output, drive fault and boot strap.
// Assumes pins synchronous to CLK and a register port with read data one cycle later.
//
// Design decisions made here: the register offsets and the plain strobed port.
module icb_pin_logic
   import icb_pkg::*;
(
   input  wire logic                   CLK,
   input  wire logic                   RST_N,
   input  wire logic [3:0]             ADDR,
   input  wire logic [15:0]            WDATA,
   input  wire logic                   WR,
   input  wire logic                   RD,
   output logic [15:0]                 RDATA,
   output logic                        IRQ,
   input  wire logic                   EXT_USER_IRQ_ONE_I,
   output logic                        EXT_USER_IRQ_ONE_O,
   output logic                        EXT_USER_IRQ_ONE_OE,
   input  wire logic                   EXT_USER_IRQ_TWO_I,
   output logic                        EXT_USER_IRQ_TWO_O,
   output logic                        EXT_USER_IRQ_TWO_OE,
   output logic                        ADC_CONV_TRIGGER_IN,
   output logic                        IRQ_ONE_PULSE,
   output logic                        IRQ_TWO_PULSE,
   input  wire logic                   CPU_CLOCK,
   input  wire logic                   WATCHDOG_CLOCK,
   input  wire logic                   CLOCK_OUT_PIN_I,
   output logic                        CLOCK_OUT_PIN_O,
   output logic                        CLOCK_OUT_PIN_OE,
   input  wire logic                   DRIVE_FAULT_IN_B,
   output logic                        EVENT_MANAGER_B_PWM_FLOAT,
   input  wire logic                   EMU_FLOAT_REQUEST_N,
   output logic                        CRYSTAL_OUT_OE,
   input  wire logic                   BOOT_EN_I,
   output logic                        EXTERNAL_FLAG_OUT,
   output logic                        EXTERNAL_FLAG_OE,
   output logic                        BOOT_ROM_SELECT
);
   import icb_pkg::*;

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [15:0]     system_ctrl_status_reg;
   logic [15:0]     pincfg;
   logic [2:0]      gpio_dir;
   logic [2:0]      gpio_out;
   logic [2:0]      irq_stat;
   logic [2:0]      irq_mask;
   logic            boot_strap;
   logic            ext_flag;
   logic            fault_prev;
   icb_boot_t       boot_state;
   icb_bus_req_t    req;
   icb_gpio_drv_t   drv;

   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire wr_system_ctrl_status_reg   = req.wr && (req.addr == OFF_SYSTEM_CTRL_STATUS_REG);
   wire wr_system_ctrl_status_reg_two  = req.wr && (req.addr == OFF_SYSTEM_CTRL_STATUS_REG_TWO);
   wire wr_cfg    = req.wr && (req.addr == OFF_PINCFG);
   wire wr_dir    = req.wr && (req.addr == OFF_GPIO_DIR);
   wire wr_out    = req.wr && (req.addr == OFF_GPIO_OUT);
   wire wr_stat   = req.wr && (req.addr == OFF_IRQ_STAT);
   wire wr_mask   = req.wr && (req.addr == OFF_IRQ_MASK);

   wire irq1_fn   = pincfg[CFG_IRQ1_FN_BIT];
   wire irq2_fn   = pincfg[CFG_IRQ2_FN_BIT];
   wire clko_fn   = pincfg[CFG_CLKO_FN_BIT];
   wire rom_part  = pincfg[CFG_ROM_BIT];
   wire soc_en    = pincfg[CFG_SOC_EN_BIT];

   wire [2:0] gpio_in = {CLOCK_OUT_PIN_I, EXT_USER_IRQ_TWO_I, EXT_USER_IRQ_ONE_I};
   wire [15:0] system_ctrl_status_reg_two_view = {11'h000, ext_flag, boot_strap, 3'h0};

   // ****************************************************************
   // Edge detection of user interrupts
   // ****************************************************************
   logic edge1;
   logic edge2;

   icb_edge_det u_edge1 (
      .CLK      (CLK),
      .RST_N    (RST_N),
      .PIN      (EXT_USER_IRQ_ONE_I),
      .RISE_SEL (pincfg[CFG_IRQ1_POL_BIT]),
      .ENABLE   (irq1_fn),
      .EDGE     (edge1)
   );

   icb_edge_det u_edge2 (
      .CLK      (CLK),
      .RST_N    (RST_N),
      .PIN      (EXT_USER_IRQ_TWO_I),
      .RISE_SEL (pincfg[CFG_IRQ2_POL_BIT]),
      .ENABLE   (irq2_fn),
      .EDGE     (edge2)
   );

   wire fault_fall = fault_prev & ~DRIVE_FAULT_IN_B;
   wire [2:0] events = {fault_fall, edge2, edge1};
   // Set wins over a write-one clear in the same cycle.
   wire [2:0] next_stat = (irq_stat & ~(wr_stat ? req.wdata[2:0] : 3'h0)) | events;

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   assign drv.o  = gpio_out;
   // Pins drive as general purpose only when software owns them and sets output; the clock pin also drives in clock function.
   assign drv.oe = gpio_dir & {~clko_fn, ~irq2_fn, ~irq1_fn};

   // The clock pin is a mux, not a flop: a registered copy could not follow CPU_CLOCK.
   wire clk_src = system_ctrl_status_reg[SYSTEM_CTRL_STATUS_REG_CLKSEL_BIT] ? WATCHDOG_CLOCK : CPU_CLOCK;

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         system_ctrl_status_reg     <= RST_SYSTEM_CTRL_STATUS_REG;
         pincfg   <= RST_PINCFG;
         gpio_dir <= RST_DIR;
         gpio_out <= RST_OUT;
         irq_mask <= RST_MASK;
      end else begin
         if (wr_system_ctrl_status_reg) system_ctrl_status_reg <= req.wdata;
         if (wr_cfg) pincfg <= req.wdata;
         if (wr_dir) gpio_dir <= req.wdata[2:0];
         if (wr_out) gpio_out <= req.wdata[2:0];
         if (wr_mask) irq_mask <= req.wdata[2:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         irq_stat   <= RST_STAT;
         fault_prev <= 1'b1;
         IRQ        <= 1'b0;
      end else begin
         irq_stat   <= next_stat;
         fault_prev <= DRIVE_FAULT_IN_B;
         IRQ        <= |(next_stat & irq_mask);
      end
   end

   // Fault float holds until software clears the fault status bit.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         EVENT_MANAGER_B_PWM_FLOAT <= 1'b0;
      end else begin
         EVENT_MANAGER_B_PWM_FLOAT <= next_stat[ST_FAULT_BIT];
      end
   end

   // ****************************************************************
   // Boot strap and flag
   // ****************************************************************
   // Strap is caught by a clocked sample while reset is held.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         boot_state <= BOOT_SAMPLE;
         boot_strap <= BOOT_EN_I;
         ext_flag   <= 1'b1;
      end else begin
         boot_state <= BOOT_FLAG;
         if (wr_system_ctrl_status_reg_two) ext_flag <= req.wdata[SYSTEM_CTRL_STATUS_REG_TWO_FLAG_BIT];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         EXTERNAL_FLAG_OUT <= 1'b1;
         EXTERNAL_FLAG_OE  <= 1'b0;
         BOOT_ROM_SELECT   <= 1'b0;
      end else begin
         EXTERNAL_FLAG_OUT <= ext_flag;
         EXTERNAL_FLAG_OE  <= 1'b1;
         // Boot selection only counts once the strap sample phase is over.
         BOOT_ROM_SELECT   <= (boot_state == BOOT_FLAG) & boot_strap & ~rom_part;
      end
   end

   // ****************************************************************
   // Pin outputs
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         EXT_USER_IRQ_ONE_O  <= 1'b0;
         EXT_USER_IRQ_ONE_OE <= 1'b0;
         EXT_USER_IRQ_TWO_O  <= 1'b0;
         EXT_USER_IRQ_TWO_OE <= 1'b0;
         CLOCK_OUT_PIN_OE    <= 1'b0;
         ADC_CONV_TRIGGER_IN <= 1'b0;
         IRQ_ONE_PULSE       <= 1'b0;
         IRQ_TWO_PULSE       <= 1'b0;
         CRYSTAL_OUT_OE      <= 1'b0;
      end else begin
         EXT_USER_IRQ_ONE_O  <= drv.o[0];
         EXT_USER_IRQ_ONE_OE <= drv.oe[0];
         EXT_USER_IRQ_TWO_O  <= drv.o[1];
         EXT_USER_IRQ_TWO_OE <= drv.oe[1];
         CLOCK_OUT_PIN_OE    <= clko_fn | drv.oe[2];
         ADC_CONV_TRIGGER_IN <= edge2 & soc_en;
         IRQ_ONE_PULSE       <= edge1;
         IRQ_TWO_PULSE       <= edge2;
         CRYSTAL_OUT_OE      <= EMU_FLOAT_REQUEST_N;
      end
   end

   always_comb begin
      CLOCK_OUT_PIN_O = clko_fn ? clk_src : drv.o[2];
   end

   // ****************************************************************
   // Read port
   // ****************************************************************
   logic [15:0] rmux;
   always_comb begin
      unique case (req.addr)
         OFF_SYSTEM_CTRL_STATUS_REG:     rmux = system_ctrl_status_reg;
         OFF_SYSTEM_CTRL_STATUS_REG_TWO:    rmux = system_ctrl_status_reg_two_view;
         OFF_PINCFG:   rmux = pincfg;
         OFF_GPIO_DIR: rmux = {13'h0000, gpio_dir};
         OFF_GPIO_OUT: rmux = {13'h0000, gpio_out};
         OFF_GPIO_IN:  rmux = {13'h0000, gpio_in};
         OFF_IRQ_STAT: rmux = {13'h0000, irq_stat};
         OFF_IRQ_MASK: rmux = {13'h0000, irq_mask};
         default:      rmux = 16'h0000;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         RDATA <= 16'h0000;
      end else begin
         RDATA <= req.rd ? rmux : 16'h0000;
      end
   end
endmodule // icb_pin_logic

// ### include/icb_pkg.sv
// Package for the interrupt, clock-output, fault and boot pin logic.
// Assumes a single 50 MHz clock domain and a plain register port.
package icb_pkg;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [3:0] OFF_SYSTEM_CTRL_STATUS_REG       = 4'h0;
   localparam logic [3:0] OFF_SYSTEM_CTRL_STATUS_REG_TWO      = 4'h1;
   localparam logic [3:0] OFF_PINCFG     = 4'h2;
   localparam logic [3:0] OFF_GPIO_DIR   = 4'h3;
   localparam logic [3:0] OFF_GPIO_OUT   = 4'h4;
   localparam logic [3:0] OFF_GPIO_IN    = 4'h5;
   localparam logic [3:0] OFF_IRQ_STAT   = 4'h6;
   localparam logic [3:0] OFF_IRQ_MASK   = 4'h7;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int SYSTEM_CTRL_STATUS_REG_CLKSEL_BIT   = 14;
   localparam int SYSTEM_CTRL_STATUS_REG_TWO_BOOT_BIT    = 3;
   localparam int SYSTEM_CTRL_STATUS_REG_TWO_FLAG_BIT    = 4;
   localparam int CFG_IRQ1_FN_BIT   = 0;
   localparam int CFG_IRQ2_FN_BIT   = 1;
   localparam int CFG_CLKO_FN_BIT   = 2;
   localparam int CFG_IRQ1_POL_BIT  = 3;
   localparam int CFG_IRQ2_POL_BIT  = 4;
   localparam int CFG_SOC_EN_BIT    = 5;
   localparam int CFG_ROM_BIT       = 6;
   localparam int ST_IRQ1_BIT       = 0;
   localparam int ST_IRQ2_BIT       = 1;
   localparam int ST_FAULT_BIT      = 2;

   // GPIO bit order: bit 0 irq one pin, bit 1 irq two pin, bit 2 clock pin.
   localparam int NUM_GPIO = 3;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [15:0] RST_SYSTEM_CTRL_STATUS_REG   = 16'h0000;
   localparam logic [15:0] RST_PINCFG = 16'h0007;
   localparam logic [2:0]  RST_DIR    = 3'h0;
   localparam logic [2:0]  RST_OUT    = 3'h0;
   localparam logic [2:0]  RST_STAT   = 3'h0;
   localparam logic [2:0]  RST_MASK   = 3'h0;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } icb_bus_req_t;

   typedef struct packed {
      logic [2:0] o;
      logic [2:0] oe;
   } icb_gpio_drv_t;

   typedef enum logic [1:0] {
      BOOT_SAMPLE = 2'b01,
      BOOT_FLAG   = 2'b10
   } icb_boot_t;

endpackage

// ### design/icb_edge_det.sv
// Synchronous edge detector with selectable polarity.
// Assumes the pin is already synchronous to CLK.
module icb_edge_det (
   input  wire logic CLK,
   input  wire logic RST_N,
   input  wire logic PIN,
   input  wire logic RISE_SEL,
   input  wire logic ENABLE,
   output logic      EDGE
);
   logic prev;
   logic fall_seen;
   logic rise_seen;

   assign rise_seen = PIN & ~prev;
   assign fall_seen = ~PIN & prev;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         prev <= 1'b1;
         EDGE <= 1'b0;
      end else begin
         prev <= PIN;
         EDGE <= ENABLE & (RISE_SEL ? rise_seen : fall_seen);
      end
   end
endmodule // icb_edge_det

// ### verification/icb_pin_chk.sv
// Port checker of the interrupt, clock, fault and boot pin logic.
// Assumes it is bound to the top module and sees only its ports.
module icb_pin_chk (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic WR,
   input wire logic IRQ,
   input wire logic EXT_USER_IRQ_ONE_I,
   input wire logic EXT_USER_IRQ_TWO_I,
   input wire logic IRQ_ONE_PULSE,
   input wire logic IRQ_TWO_PULSE,
   input wire logic ADC_CONV_TRIGGER_IN,
   input wire logic DRIVE_FAULT_IN_B,
   input wire logic EVENT_MANAGER_B_PWM_FLOAT,
   input wire logic EMU_FLOAT_REQUEST_N,
   input wire logic CRYSTAL_OUT_OE,
   input wire logic EXTERNAL_FLAG_OUT,
   input wire logic EXTERNAL_FLAG_OE,
   input wire logic EXT_USER_IRQ_ONE_OE,
   input wire logic EXT_USER_IRQ_TWO_OE,
   input wire logic CLOCK_OUT_PIN_OE
);
   default clocking cb @(posedge CLK); endclocking
   // Pin change first sampled at edge N shows as a pulse sampled at edge N+2.
   AST_PULSE_SRC: assert property (disable iff (!RST_N) IRQ_ONE_PULSE |-> $past(EXT_USER_IRQ_ONE_I, 2) != $past(EXT_USER_IRQ_ONE_I, 3))
      else $error("pulse without pin edge");
   AST_PULSE_ONE: assert property (disable iff (!RST_N) IRQ_ONE_PULSE |=> !IRQ_ONE_PULSE)
      else $error("pulse too long");
   AST_IRQ_CAUSE: assert property (disable iff (!RST_N) $rose(IRQ) |-> IRQ_ONE_PULSE || IRQ_TWO_PULSE || EVENT_MANAGER_B_PWM_FLOAT || $past(WR))
      else $error("interrupt without cause");
   AST_SOC_SRC: assert property (disable iff (!RST_N) ADC_CONV_TRIGGER_IN |-> $past(EXT_USER_IRQ_TWO_I, 2) != $past(EXT_USER_IRQ_TWO_I, 3))
      else $error("trigger without pin edge");
   AST_FAULT: assert property (disable iff (!RST_N) $past(RST_N) && $fell(DRIVE_FAULT_IN_B) |-> ##1 EVENT_MANAGER_B_PWM_FLOAT)
      else $error("fault edge missed");
   AST_FAULT_HOLD: assert property (disable iff (!RST_N) EVENT_MANAGER_B_PWM_FLOAT && !WR |=> EVENT_MANAGER_B_PWM_FLOAT)
      else $error("float released early");
   AST_XTAL: assert property (disable iff (!RST_N) !EMU_FLOAT_REQUEST_N |=> !CRYSTAL_OUT_OE)
      else $error("crystal pin driven");
   AST_FLAG_RST: assert property (!RST_N |=> EXTERNAL_FLAG_OUT && !EXTERNAL_FLAG_OE)
      else $error("strap pin driven in reset");
   AST_FLAG_UP: assert property (disable iff (!RST_N) $rose(RST_N) |=> EXTERNAL_FLAG_OE && EXTERNAL_FLAG_OUT)
      else $error("flag not high after reset");
   AST_RST_PINS: assert property (!RST_N |=> !(EXT_USER_IRQ_ONE_OE || EXT_USER_IRQ_TWO_OE || CLOCK_OUT_PIN_OE))
      else $error("pin driven in reset");
endmodule // icb_pin_chk

// ### verification/icb_board.sv
// Board model: interrupt pin drivers and the two clock sources.
// Assumes the bench changes drive levels just after a rising edge.
module icb_board (
   input  wire logic CLK,
   input  wire logic DRV_ONE,
   input  wire logic DRV_TWO,
   input  wire logic OE_ONE,
   input  wire logic O_ONE,
   input  wire logic OE_TWO,
   input  wire logic O_TWO,
   output logic      PIN_ONE,
   output logic      PIN_TWO,
   output logic      CPU_CLK,
   output logic      WD_CLK
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div;
   // The device wins a pin only while it drives it.
   assign PIN_ONE = OE_ONE ? O_ONE : DRV_ONE;
   assign PIN_TWO = OE_TWO ? O_TWO : DRV_TWO;
   initial begin
      CPU_CLK = 1'b0;
      WD_CLK = 1'b0;
      div = 2'h0;
   end
   // Different rates, so a wrong clock selection shows.
   always @(posedge CLK) begin
      CPU_CLK <= ~CPU_CLK;
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      if (div == 2'h2) WD_CLK <= ~WD_CLK;
   end
endmodule // icb_board

// ### verification/icb_pin_logic_bench.sv
// Self-checking bench of the pin logic with board model and checker.
// Assumes the design package is compiled first.
module icb_pin_logic_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import icb_pkg::*;
   logic CLK, RST_N, WR, RD, IRQ, ADC_CONV_TRIGGER_IN, IRQ_ONE_PULSE, IRQ_TWO_PULSE;
   logic [3:0] ADDR;
   logic [15:0] WDATA, RDATA;
   logic EXT_USER_IRQ_ONE_I, EXT_USER_IRQ_ONE_O, EXT_USER_IRQ_ONE_OE, EXT_USER_IRQ_TWO_I;
   logic EXT_USER_IRQ_TWO_O, EXT_USER_IRQ_TWO_OE, CPU_CLOCK, WATCHDOG_CLOCK, CLOCK_OUT_PIN_I;
   logic CLOCK_OUT_PIN_O, CLOCK_OUT_PIN_OE, DRIVE_FAULT_IN_B, EVENT_MANAGER_B_PWM_FLOAT;
   logic EMU_FLOAT_REQUEST_N, CRYSTAL_OUT_OE, BOOT_EN_I, EXTERNAL_FLAG_OUT, EXTERNAL_FLAG_OE;
   logic BOOT_ROM_SELECT, drv_one, drv_two;
   int failures = 0, n_checks = 0, cyc = 0, n_soc = 0;
   icb_pin_logic u_icb_pin_logic (.*);
   icb_board u_icb_board (.CLK(CLK), .DRV_ONE(drv_one), .DRV_TWO(drv_two), .OE_ONE(EXT_USER_IRQ_ONE_OE),
      .O_ONE(EXT_USER_IRQ_ONE_O), .OE_TWO(EXT_USER_IRQ_TWO_OE), .O_TWO(EXT_USER_IRQ_TWO_O),
      .PIN_ONE(EXT_USER_IRQ_ONE_I), .PIN_TWO(EXT_USER_IRQ_TWO_I), .CPU_CLK(CPU_CLOCK), .WD_CLK(WATCHDOG_CLOCK));
   // The clock pin has a pull-up, so it reads high while undriven.
   assign CLOCK_OUT_PIN_I = CLOCK_OUT_PIN_OE ? CLOCK_OUT_PIN_O : 1'b1;
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cyc++;
      if (ADC_CONV_TRIGGER_IN === 1'b1) n_soc++;
      if (cyc == 3000) begin
         failures++;
         test_done;
      end
   end
   // ************
   // Tasks
   // ************
   task automatic test_done;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({15'h0, got}, {15'h0, exp});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      chk(RDATA, e);
   endtask
   // Pin changes reach status two edges later, one for the fault; put waits three.
   task automatic put(input logic one, input logic two, input logic flt, input logic emu);
      @(posedge CLK);
      drv_one <= one;
      drv_two <= two;
      DRIVE_FAULT_IN_B <= flt;
      EMU_FLOAT_REQUEST_N <= emu;
      tick(3);
   endtask
   task automatic rst(input int n, input logic s);
      @(posedge CLK);
      RST_N <= 1'b0;
      BOOT_EN_I <= s;
      repeat (n) @(posedge CLK);
      RST_N <= 1'b1;
      tick(1);
   endtask
   // ************
   // Sequence
   // ************
   initial begin
      {RST_N, WR, RD, ADDR, WDATA} = '0;
      {drv_one, drv_two, DRIVE_FAULT_IN_B, EMU_FLOAT_REQUEST_N, BOOT_EN_I} = 5'h1f;
      for (int r = 0; r < 2; r++) begin
         rst(10, r[0]);
         chk({14'h0, EXTERNAL_FLAG_OE, EXTERNAL_FLAG_OUT}, 16'h0003);
         rd(OFF_SYSTEM_CTRL_STATUS_REG_TWO, {12'h001, r[0], 3'h0});
      end
      rd(OFF_GPIO_DIR, 16'h0000);
      rd(OFF_PINCFG, RST_PINCFG);
      chk1(BOOT_ROM_SELECT, 1'b1);
      rd(4'h8, 16'h0000);
      wr(OFF_IRQ_MASK, 16'h0007);
      put(1'b0, 1'b1, 1'b1, 1'b1);
      rd(OFF_IRQ_STAT, 16'h0001);
      chk1(IRQ, 1'b1);
      wr(OFF_IRQ_STAT, 16'h0001);
      put(1'b1, 1'b1, 1'b1, 1'b1);
      rd(OFF_IRQ_STAT, 16'h0000);
      chk1(IRQ, 1'b0);
      wr(OFF_PINCFG, 16'h002f);
      put(1'b0, 1'b0, 1'b1, 1'b1);
      rd(OFF_IRQ_STAT, 16'h0002);
      chk(n_soc[15:0], 16'h0001);
      put(1'b1, 1'b1, 1'b1, 1'b1);
      rd(OFF_IRQ_STAT, 16'h0003);
      wr(OFF_IRQ_STAT, 16'h0003);
      wr(OFF_PINCFG, 16'h002c);
      put(1'b0, 1'b0, 1'b1, 1'b1);
      put(1'b1, 1'b1, 1'b1, 1'b1);
      rd(OFF_IRQ_STAT, 16'h0000);
      for (int s = 0; s < 2; s++) begin
         wr(OFF_SYSTEM_CTRL_STATUS_REG, s[0] ? 16'h4000 : 16'h0000);
         repeat (4) begin
            tick(1);
            chk1(CLOCK_OUT_PIN_O, s[0] ? WATCHDOG_CLOCK : CPU_CLOCK);
         end
      end
      wr(OFF_PINCFG, 16'h0000);
      wr(OFF_GPIO_DIR, 16'h0007);
      for (int v = 0; v < 2; v++) begin
         wr(OFF_GPIO_OUT, v[0] ? 16'h0007 : 16'h0000);
         tick(2);
         chk({10'h0, EXT_USER_IRQ_ONE_OE, EXT_USER_IRQ_ONE_O, EXT_USER_IRQ_TWO_OE, EXT_USER_IRQ_TWO_O,
            CLOCK_OUT_PIN_OE, CLOCK_OUT_PIN_O}, {10'h0, 1'b1, v[0], 1'b1, v[0], 1'b1, v[0]});
      end
      rd(OFF_GPIO_IN, 16'h0007);
      put(1'b1, 1'b1, 1'b0, 1'b1);
      chk1(EVENT_MANAGER_B_PWM_FLOAT, 1'b1);
      chk1(IRQ, 1'b1);
      rd(OFF_IRQ_STAT, 16'h0004);
      wr(OFF_IRQ_STAT, 16'h0004);
      tick(2);
      chk1(EVENT_MANAGER_B_PWM_FLOAT, 1'b0);
      put(1'b1, 1'b1, 1'b0, 1'b0);
      chk1(CRYSTAL_OUT_OE, 1'b0);
      put(1'b1, 1'b1, 1'b1, 1'b1);
      chk1(CRYSTAL_OUT_OE, 1'b1);
      wr(OFF_PINCFG, 16'h0040);
      tick(2);
      chk1(BOOT_ROM_SELECT, 1'b0);
      test_done;
   end
endmodule // icb_pin_logic_bench
bind icb_pin_logic icb_pin_chk u_icb_pin_chk (.*);
